// ---- common/pss_pkg.sv ----
// Package for the PHY status summary register block
package pss_pkg;
   // ----------------------------------------------------------------
   // Register map as word indices; the byte address is the index times four
   // ----------------------------------------------------------------
   localparam logic [7:0] PSS_IDX_BASIC_STATUS = 8'h01;
   localparam logic [7:0] PSS_IDX_AUTONEG_EXP = 8'h06;
   localparam logic [7:0] PSS_IDX_SUMMARY = 8'h10;
   localparam logic [7:0] PSS_IDX_INTR_STATUS = 8'h12;
   localparam logic [7:0] PSS_IDX_FALSE_CARRIER = 8'h14;
   localparam logic [7:0] PSS_IDX_RX_ERROR = 8'h15;
   localparam logic [7:0] PSS_IDX_TENBASE = 8'h1A;
   localparam int PSS_ADDR_W = 10;
   localparam logic [31:0] PSS_RESET_VALUE = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Field positions in the summary word
   // ----------------------------------------------------------------
   localparam int PSS_B_LINK = 0;
   localparam int PSS_B_SPEED10 = 1;
   localparam int PSS_B_DUPLEX = 2;
   localparam int PSS_B_LOOPBACK = 3;
   localparam int PSS_B_AN_DONE = 4;
   localparam int PSS_B_JABBER = 5;
   localparam int PSS_B_REM_FAULT = 6;
   localparam int PSS_B_INT_PEND = 7;
   localparam int PSS_B_PAGE_RX = 8;
   localparam int PSS_B_DESCR_LOCK = 9;
   localparam int PSS_B_SIG_DET = 10;
   localparam int PSS_B_FALSE_CARR = 11;
   localparam int PSS_B_POLARITY = 12;
   localparam int PSS_B_RX_ERR = 13;
   localparam int PSS_B_CROSSOVER = 14;
endpackage : pss_pkg

// ---- hw/pss_status.sv ----
// PHY status summary register with APB slave and clear-on-read tracking
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module pss_status (
   input wire logic pclk,
   input wire logic presetn,
   // APB slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pss_pkg::PSS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Events and levels from the receive, negotiation and crossover logic
   input wire logic rx_error_event,
   input wire logic false_carrier_event,
   input wire logic polarity_inverted_event,
   input wire logic signal_detect,
   input wire logic descrambler_lock,
   input wire logic page_received_event,
   input wire logic interrupt_pending,
   input wire logic remote_fault_event,
   input wire logic jabber_detected,
   input wire logic autoneg_complete,
   input wire logic loopback_enabled,
   input wire logic full_duplex,
   input wire logic speed_10,
   input wire logic link_valid,
   input wire logic crossover_swapped,
   // Read strobes; each source register runs its own clear-on-read
   output logic rx_error_count_rd,
   output logic false_carrier_count_rd,
   output logic tenbase_status_rd,
   output logic autoneg_expansion_rd,
   output logic basic_status_rd,
   output logic interrupt_status_rd
);
   import pss_pkg::*;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic access;
   logic rd_access;
   logic setup;
   logic setup_rd;
   logic [PSS_ADDR_W-1:0] summary_addr;
   logic hit_summary;
   logic hit_basic;
   logic hit_autoneg;
   logic hit_intr;
   logic hit_false_carr;
   logic hit_rx_err;
   logic hit_tenbase;
   logic hit_source;

   // ---------------------------------------------------------------
   // Status state
   // ---------------------------------------------------------------
   logic rx_err;
   logic false_carr;
   logic polarity;
   logic page_rx;
   logic rem_fault;
   logic sig_det;
   logic descr_lock;
   logic sig_det_low;
   logic lock_low;
   logic [15:0] summary;

   // Each register is one aligned word, so the two low address bits are zero
   function automatic logic hit(input logic [PSS_ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   // Setup selects the read data, access carries the side effects
   assign setup = psel && !penable;
   assign setup_rd = setup && !pwrite;
   assign access = psel && penable;
   assign rd_access = access && !pwrite;
   assign summary_addr = {PSS_IDX_SUMMARY, 2'b00};
   assign hit_summary = (paddr == summary_addr);
   assign hit_basic = hit(paddr, PSS_IDX_BASIC_STATUS);
   assign hit_autoneg = hit(paddr, PSS_IDX_AUTONEG_EXP);
   assign hit_intr = hit(paddr, PSS_IDX_INTR_STATUS);
   assign hit_false_carr = hit(paddr, PSS_IDX_FALSE_CARRIER);
   assign hit_rx_err = hit(paddr, PSS_IDX_RX_ERROR);
   assign hit_tenbase = hit(paddr, PSS_IDX_TENBASE);
   assign hit_source = hit_basic || hit_autoneg || hit_intr
      || hit_false_carr || hit_rx_err || hit_tenbase;

   // ---------------------------------------------------------------
   // Bus response
   // ---------------------------------------------------------------
   // Zero wait states; errors only for unmapped addresses
   assign pready = 1'b1;
   assign pslverr = access && !hit_summary && !hit_source;

   // ---------------------------------------------------------------
   // Source register read strobes
   // ---------------------------------------------------------------
   // Only reads count: a write to a counter must not clear its latch
   // receive error clear
   assign rx_error_count_rd = rd_access && hit_rx_err;
   assign false_carrier_count_rd = rd_access && hit_false_carr;
   assign tenbase_status_rd = rd_access && hit_tenbase;
   assign autoneg_expansion_rd = rd_access && hit_autoneg;
   assign basic_status_rd = rd_access && hit_basic;
   assign interrupt_status_rd = rd_access && hit_intr;

   // ---------------------------------------------------------------
   // Latching-high mirrors; event wins over a clearing read,
   // so an event that races the source register read is never lost
   // ---------------------------------------------------------------
   // receive error latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_err <= 1'b0;
      end else if (rx_error_event) begin
         rx_err <= 1'b1;
      end else if (rx_error_count_rd) begin
         rx_err <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         false_carr <= 1'b0;
      end else if (false_carrier_event) begin
         false_carr <= 1'b1;
      end else if (false_carrier_count_rd) begin
         false_carr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         polarity <= 1'b0;
      end else if (polarity_inverted_event) begin
         polarity <= 1'b1;
      end else if (tenbase_status_rd) begin
         polarity <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_rx <= 1'b0;
      end else if (page_received_event) begin
         page_rx <= 1'b1;
      end else if (autoneg_expansion_rd) begin
         page_rx <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_fault <= 1'b0;
      end else if (remote_fault_event) begin
         rem_fault <= 1'b1;
      end else if (basic_status_rd) begin
         rem_fault <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Latching-low indications, released by a read of the summary
   // A drop stays visible until software has read it once
   // ---------------------------------------------------------------
   // signal detect latch low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_det_low <= 1'b1;
      end else if (!signal_detect) begin
         sig_det_low <= 1'b1;
      end else if (rd_access && hit_summary) begin
         sig_det_low <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_low <= 1'b1;
      end else if (!descrambler_lock) begin
         lock_low <= 1'b1;
      end else if (rd_access && hit_summary) begin
         lock_low <= 1'b0;
      end
   end

   // Latch starts dropped so the first read after reset shows zero
   assign sig_det = signal_detect && !sig_det_low;
   assign descr_lock = descrambler_lock && !lock_low;

   // ---------------------------------------------------------------
   // Summary word
   // ---------------------------------------------------------------
   always_comb begin
      // Bit 15 is reserved and stays zero
      summary = 16'h0000;
      summary[PSS_B_CROSSOVER] = crossover_swapped;
      summary[PSS_B_RX_ERR] = rx_err;
      summary[PSS_B_POLARITY] = polarity;
      summary[PSS_B_FALSE_CARR] = false_carr;
      summary[PSS_B_SIG_DET] = sig_det;
      summary[PSS_B_DESCR_LOCK] = descr_lock;
      summary[PSS_B_PAGE_RX] = page_rx;
      summary[PSS_B_INT_PEND] = interrupt_pending;
      summary[PSS_B_REM_FAULT] = rem_fault;

      // Live levels pass straight through; their owners set the timing
      // jabber mirror
      summary[PSS_B_JABBER] = jabber_detected;
      summary[PSS_B_AN_DONE] = autoneg_complete;
      summary[PSS_B_LOOPBACK] = loopback_enabled;
      summary[PSS_B_DUPLEX] = full_duplex;
      summary[PSS_B_SPEED10] = speed_10;
      summary[PSS_B_LINK] = link_valid;
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Taken at the setup edge so it stands through the access phase,
   // before the latch-low release at the access edge can change it;
   // every other address reads zero
   // writes ignored, reset zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= PSS_RESET_VALUE;
      end else if (setup_rd && hit_summary) begin
         prdata <= {16'h0000, summary};
      end else if (setup) begin
         prdata <= PSS_RESET_VALUE;
      end
   end

   // Write data has no destination in a read-only register
   logic unused_bits;
   assign unused_bits = ^{pwdata, pstrb};
endmodule : pss_status

// ---- test/pss_status_assertions.sv ----
// Port checks for the status summary block
`timescale 1ns/1ps
module pss_status_assertions (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [pss_pkg::PSS_ADDR_W-1:0] paddr,
   input logic [31:0] prdata,
   input logic jabber_detected,
   input logic autoneg_complete,
   input logic loopback_enabled,
   input logic full_duplex,
   input logic speed_10,
   input logic link_valid,
   input logic rx_error_event,
   input logic false_carrier_event,
   input logic signal_detect,
   input logic rx_error_count_rd,
   input logic false_carrier_count_rd,
   input logic tenbase_status_rd,
   input logic autoneg_expansion_rd,
   input logic basic_status_rd,
   input logic interrupt_status_rd
);
   import pss_pkg::*;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   wire rd = psel && penable && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable && !pwrite && paddr == 10'h040;
   endsequence
   // Summary captures levels at setup
   AST_LIVE: assert property (s_setup |=> prdata[5:0] ==
      {$past(jabber_detected), $past(autoneg_complete), $past(loopback_enabled),
      $past(full_duplex), $past(speed_10), $past(link_valid)})
      else $error("live status bits wrong");
   AST_UPPER: assert property (rd |-> prdata[31:15] == 17'h0)
      else $error("unused upper bits not zero");
   sequence s_rxe_held;
      rx_error_event ##1 !rx_error_count_rd ##1 s_setup;
   endsequence
   sequence s_fc_held;
      false_carrier_event ##1 !false_carrier_count_rd ##1 s_setup;
   endsequence
   sequence s_drop_seen;
      !signal_detect ##1 !rd ##1 s_setup;
   endsequence
   AST_RXE_SET: assert property (s_rxe_held |=> prdata[PSS_B_RX_ERR])
      else $error("receive error latch lost");
   AST_FC_SET: assert property (s_fc_held |=> prdata[PSS_B_FALSE_CARR])
      else $error("false carrier latch lost");
   AST_SD_LOW: assert property (s_drop_seen |=> !prdata[PSS_B_SIG_DET])
      else $error("signal detect drop not reported");
   AST_RXE_RD: assert property (rx_error_count_rd == (rd && paddr == 10'h054))
      else $error("rx error count read strobe wrong");
   AST_FC_RD: assert property (false_carrier_count_rd == (rd && paddr == 10'h050))
      else $error("false carrier read strobe wrong");
   AST_TEN_RD: assert property (tenbase_status_rd == (rd && paddr == 10'h068))
      else $error("tenbase read strobe wrong");
   AST_AN_RD: assert property (autoneg_expansion_rd == (rd && paddr == 10'h018))
      else $error("expansion read strobe wrong");
   AST_BS_RD: assert property (basic_status_rd == (rd && paddr == 10'h004))
      else $error("basic status read strobe wrong");
   AST_INT_RD: assert property (interrupt_status_rd == (rd && paddr == 10'h048))
      else $error("interrupt status read strobe wrong");
endmodule : pss_status_assertions

// ---- test/pss_status_bench.sv ----
// Self-checking bench for the status summary block
`timescale 1ns/1ps
bind pss_status pss_status_assertions chk (.*);
module pss_status_bench;
   import pss_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata, got;
   logic pready, pslverr, err;
   logic [4:0] ev = 5'h00;
   logic [9:0] lv = 10'h000;
   int error_cnt = 0;
   int total_checks = 0;
   int pos[10] = '{10, 9, 7, 5, 4, 3, 2, 1, 0, 14};
   int lbit[5] = '{13, 11, 12, 8, 6};
   logic [9:0] clr[5] = '{10'h054, 10'h050, 10'h068, 10'h018, 10'h004};
   always #2 pclk = ~pclk;
   pss_status uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hF), .prdata, .pready, .pslverr, .rx_error_event(ev[0]),
      .false_carrier_event(ev[1]), .polarity_inverted_event(ev[2]),
      .page_received_event(ev[3]), .remote_fault_event(ev[4]), .signal_detect(lv[0]),
      .descrambler_lock(lv[1]), .interrupt_pending(lv[2]), .jabber_detected(lv[3]),
      .autoneg_complete(lv[4]), .loopback_enabled(lv[5]), .full_duplex(lv[6]),
      .speed_10(lv[7]), .link_valid(lv[8]), .crossover_swapped(lv[9]),
      .rx_error_count_rd(), .false_carrier_count_rd(), .tenbase_status_rd(),
      .autoneg_expansion_rd(), .basic_status_rd(), .interrupt_status_rd());
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         give_verdict();
      end
      got = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(got, exp);
   endtask : rd
   task automatic pulse(input int i);
      @(posedge pclk);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
   endtask : pulse
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(10'h040, 32'h0);
      apb(10'h040, 1'b1, 32'hFFFF_FFFF);
      rd(10'h040, 32'h0);
      // latch-low release; a drop is only seen if it is read
      lv <= 10'h003;
      rd(10'h040, 32'h0);
      rd(10'h040, 32'h600);
      lv <= 10'h000;
      @(posedge pclk);
      lv <= 10'h003;
      rd(10'h040, 32'h0);
      rd(10'h040, 32'h600);
      for (int i = 2; i < 10; i++) begin
         lv <= 10'h003 | (10'h001 << i);
         rd(10'h040, 32'h600 | (32'h1 << pos[i]));
      end
      lv <= 10'h1D3;
      rd(10'h040, 32'h617);
      lv <= 10'h003;
      rd(10'h048, 32'h0);
      for (int i = 0; i < 5; i++) begin
         pulse(i);
         rd(10'h040, 32'h600 | (32'h1 << lbit[i]));
         rd(clr[(i + 1) % 5], 32'h0);
         rd(10'h040, 32'h600 | (32'h1 << lbit[i]));
         rd(clr[i], 32'h0);
         rd(10'h040, 32'h600);
      end
      pulse(0);
      apb(10'h054, 1'b1, 32'h0);
      rd(10'h040, 32'h2600);
      rd(10'h054, 32'h0);
      pulse(4);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(10'h040, 32'h0);
      apb(10'h3FC, 1'b0, 32'h0);
      chk({31'h0, err}, 32'h1);
      give_verdict();
   end
endmodule : pss_status_bench
